// ### logic/fscd_cmd_decode.sv
`timescale 1ns/1ps
`default_nettype none
// decodes one opcode against the present power path state
module fscd_cmd_decode
    import fscd_pkg::*;
(
    input wire logic [7:0] opcode, // opcode to decode
    input wire fscd_power_t pwr, // present power state
    output logic wake, // wake host port
    output logic det_off, // turn detection off
    output logic det_on, // turn detection on
    output logic sink_on, // enable sink path
    output logic src_def, // source default voltage
    output logic src_hv, // source high voltage
    output logic reject // illegal in present state
);
    always_comb begin
        wake = 1'b0;
        det_off = 1'b0;
        det_on = 1'b0;
        sink_on = 1'b0;
        src_def = 1'b0;
        src_hv = 1'b0;
        reject = 1'b0;
        unique case (opcode)
            FSCD_OP_WAKE: wake = 1'b1;
            FSCD_OP_DIS_DET: begin
                reject = pwr.sourcing | pwr.sinking;
                det_off = ~reject;
            end
            FSCD_OP_EN_DET: det_on = 1'b1;
            FSCD_OP_SINK: begin
                reject = pwr.sourcing;
                sink_on = ~reject;
                det_on = ~reject;
            end
            FSCD_OP_SRC_DEF: begin
                reject = pwr.sinking;
                src_def = ~reject;
                det_on = ~reject;
            end
            FSCD_OP_SRC_HV: begin
                reject = ~pwr.sourcing | pwr.source_hv | pwr.sinking | ~pwr.hv_capable;
                src_hv = ~reject;
            end
            default: begin
            end
        endcase
    end
endmodule
`default_nettype wire

// ### logic/fscd_pkg.sv
package fscd_pkg;
    // register offsets
    localparam logic [7:0] FSCD_FAULT_ADDR = 8'h1F;
    localparam logic [7:0] FSCD_CMD_ADDR = 8'h23;
    // fault field positions
    localparam int FSCD_POR_BIT = 7;
    localparam int FSCD_AUTO_DISCH_BIT = 5;
    localparam int FSCD_FORCE_DISCH_BIT = 4;
    localparam int FSCD_OCP_BIT = 1;
    localparam int FSCD_ACCESS_ERR_BIT = 0;
    localparam logic [7:0] FSCD_FAULT_RESET = 8'h80;
    localparam logic [7:0] FSCD_FAULT_MASK = 8'hB3;
    localparam logic [7:0] FSCD_CMD_RESET = 8'h00;
    // opcodes
    localparam logic [7:0] FSCD_OP_WAKE = 8'h11;
    localparam logic [7:0] FSCD_OP_DIS_DET = 8'h22;
    localparam logic [7:0] FSCD_OP_EN_DET = 8'h33;
    localparam logic [7:0] FSCD_OP_SINK = 8'h55;
    localparam logic [7:0] FSCD_OP_SRC_DEF = 8'h77;
    localparam logic [7:0] FSCD_OP_SRC_HV = 8'h88;
    // least transmit buffer fill for a sink-transmit request
    localparam logic [7:0] FSCD_TX_MIN_BYTES = 8'h02;
    // power path state presented to the decoder
    typedef struct packed {
        logic sourcing;
        logic sinking;
        logic source_hv;
        logic hv_capable;
    } fscd_power_t;
    // fault events, one-cycle pulses
    typedef struct packed {
        logic auto_discharge_failure_flag;
        logic forced_disch_fail;
        logic ocp;
        logic sink_tx_req;
        logic invalid_conn;
    } fscd_events_t;
endpackage

// ### logic/fscd_top.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - power-on reset loads fault register 0x80, bit 7 marking a power reset
// - software reset never sets the power-reset flag
// - auto discharge failure after disconnect sets bit 5 when enabled
// - forced discharge failure sets bit 4, otherwise it reads zero
// - cable supply over-current latches bit 1 until software clears it
// - flags latch; writing one clears only that flag
// - disable-detection while sourcing or sinking is rejected with access error
// - start-sinking while sourcing is rejected with access error
// - source-default while sinking is rejected with access error
// - source-high-voltage rejected unless sourcing 5 V, not sinking, capable
// - entering invalid-connection state sets access error
// - command register at 23h resets 0x00 and clears after acting
// - wake opcode only wakes the host serial port
// - disable opcode stops presence detection so present status freezes
// - enable opcode turns presence detection on
// - start-sinking enables sink path and detection unless sourcing
// - source-high-voltage requests high voltage when legal
module fscd_top
    import fscd_pkg::*;
(
    input wire logic clock, // 100 MHz clock
    input wire logic rst, // power-on reset, async high
    input wire logic software_reset, // commanded reset pulse
    input wire logic [7:0] reg_addr, // register address
    input wire logic [7:0] reg_wdata, // write data
    input wire logic reg_we, // write strobe
    output logic [7:0] reg_rdata, // read data
    input wire fscd_events_t events, // fault event pulses
    input wire logic auto_discharge_enable, // automatic discharge on
    input wire logic [7:0] transmit_byte_count, // transmit buffer fill
    input wire logic hv_capable, // device can source high voltage
    input wire logic bus_power_raw, // vbus comparator pin
    output logic [7:0] fault_latch_status, // fault register
    output logic [7:0] command_trigger, // command register
    output logic wake_host_port, // host port wake pulse
    output logic presence_detect_en, // presence detection on
    output logic bus_power_present_status, // vbus present
    output logic sink_path_en, // sink path on
    output logic source_en, // sourcing vbus
    output logic source_hv // sourcing high voltage
);
    logic [7:0] fault_r;
    logic [7:0] fault_nxt;
    logic [7:0] cmd_r;
    logic det_en_r;
    logic sink_r;
    logic src_r;
    logic hv_r;
    logic wake_r;
    logic present_r;
    logic [2:0] pin_sync_r;
    logic d_wake;
    logic d_off;
    logic d_on;
    logic d_sink;
    logic d_def;
    logic d_hv;
    logic d_rej;
    logic cmd_pending;
    logic err_evt;
    fscd_power_t pwr;
    logic fault_wr;
    logic cmd_wr;
    logic [7:0] rdata_r;

    // a write strobe aimed at one register offset
    function automatic logic wr_hit(input logic we, input logic [7:0] addr,
            input logic [7:0] target);
        return we && (addr == target);
    endfunction

    assign fault_wr = wr_hit(reg_we, reg_addr, FSCD_FAULT_ADDR);
    assign cmd_wr = wr_hit(reg_we, reg_addr, FSCD_CMD_ADDR);

    assign pwr = '{sourcing: src_r, sinking: sink_r, source_hv: hv_r, hv_capable: hv_capable};
    assign cmd_pending = (cmd_r != FSCD_CMD_RESET);

    fscd_cmd_decode u_decode (
        .opcode(cmd_r),
        .pwr(pwr),
        .wake(d_wake),
        .det_off(d_off),
        .det_on(d_on),
        .sink_on(d_sink),
        .src_def(d_def),
        .src_hv(d_hv),
        .reject(d_rej)
    );

    assign err_evt = (cmd_pending & d_rej)
        | (events.sink_tx_req & (transmit_byte_count < FSCD_TX_MIN_BYTES))
        | events.invalid_conn;

    always_comb begin
        fault_nxt = fault_r;
        if (fault_wr) begin
            fault_nxt = fault_r & ~(reg_wdata & FSCD_FAULT_MASK);
        end
        // set wins over a same-cycle clear
        // auto discharge failure
        if (events.auto_discharge_failure_flag && auto_discharge_enable) begin
            fault_nxt[FSCD_AUTO_DISCH_BIT] = 1'b1;
        end
        if (events.forced_disch_fail) begin
            fault_nxt[FSCD_FORCE_DISCH_BIT] = 1'b1;
        end
        if (events.ocp) begin
            fault_nxt[FSCD_OCP_BIT] = 1'b1;
        end
        if (err_evt) begin
            fault_nxt[FSCD_ACCESS_ERR_BIT] = 1'b1;
        end
    end

    // software reset leaves the power flag alone
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            fault_r <= FSCD_FAULT_RESET;
        end else begin
            fault_r <= fault_nxt & FSCD_FAULT_MASK;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cmd_r <= FSCD_CMD_RESET;
        end else if (software_reset) begin
            cmd_r <= FSCD_CMD_RESET;
        end else if (cmd_wr) begin
            cmd_r <= reg_wdata;
        end else begin
            cmd_r <= FSCD_CMD_RESET;
        end
    end

    // power path and detection; rejected codes have all actions low
    // rejection keeps state
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            det_en_r <= 1'b1;
            sink_r <= 1'b0;
            src_r <= 1'b0;
            hv_r <= 1'b0;
        end else if (software_reset) begin
            det_en_r <= 1'b1;
            sink_r <= 1'b0;
            src_r <= 1'b0;
            hv_r <= 1'b0;
        end else if (cmd_pending) begin
            if (d_off) begin
                det_en_r <= 1'b0;
            end else if (d_on) begin
                det_en_r <= 1'b1;
            end
            if (d_sink) begin
                sink_r <= 1'b1;
            end
            if (d_def) begin
                src_r <= 1'b1;
                hv_r <= 1'b0;
            end
            if (d_hv) begin
                hv_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wake_r <= 1'b0;
        end else begin
            wake_r <= cmd_pending & d_wake;
        end
    end

    // pin synchroniser; first stage read only by the second
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pin_sync_r <= 3'b000;
        end else begin
            pin_sync_r <= {pin_sync_r[1:0], bus_power_raw};
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            present_r <= 1'b0;
        end else if (det_en_r && (pin_sync_r[1] == pin_sync_r[2])) begin
            present_r <= pin_sync_r[2];
        end
    end

    // registered read mux; data shows one cycle after the address, so the
    // host must hold the address for a cycle before taking the value
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdata_r <= 8'h00;
        end else begin
            unique case (reg_addr)
                FSCD_FAULT_ADDR: rdata_r <= fault_r;
                FSCD_CMD_ADDR: rdata_r <= cmd_r;
                default: rdata_r <= 8'h00;
            endcase
        end
    end

    assign reg_rdata = rdata_r;
    assign fault_latch_status = fault_r;
    assign command_trigger = cmd_r;
    assign wake_host_port = wake_r;
    assign presence_detect_en = det_en_r;
    assign bus_power_present_status = present_r;
    assign sink_path_en = sink_r;
    assign source_en = src_r;
    assign source_hv = hv_r;
endmodule
`default_nettype wire

// ### test/fscd_bench.sv
`timescale 1ns/1ps
`default_nettype none
module fscd_bench
    import fscd_pkg::*;
;
    logic clock = 1'b0, rst = 1'b1, software_reset = 1'b0, auto_discharge_enable = 1'b1;
    logic hv_capable = 1'b0, bus_power_raw = 1'b0;
    logic [7:0] transmit_byte_count = 8'h00, v;
    fscd_events_t events = '0;
    wire logic [7:0] reg_addr, reg_wdata, reg_rdata, fault_latch_status, command_trigger;
    wire logic reg_we, wake_host_port, presence_detect_en, bus_power_present_status;
    wire logic sink_path_en, source_en, source_hv;
    wire logic [7:0] pw = {4'h0, source_hv, source_en, sink_path_en, presence_detect_en};
    int n_errors = 0, num_checks = 0;
    localparam logic [7:0] EXP [5] = '{8'h01, 8'h01, 8'h02, 8'h10, 8'h20};
    localparam logic [7:0] OPS [12] = '{8'h55, 8'h77, 8'h22, 8'h88, 8'h33, 8'h88,
        8'h77, 8'h55, 8'h22, 8'h88, 8'h88, 8'h88};
    localparam logic [7:0] PWS [12] = '{8'h03, 8'h03, 8'h03, 8'h03, 8'h01, 8'h01,
        8'h05, 8'h05, 8'h05, 8'h05, 8'h0D, 8'h0D};
    localparam logic [11:0] ERR = 12'hBAE;
    localparam logic [11:0] HV = 12'hC00;
    always #5 clock = ~clock;
    fscd_top DUT (.clock(clock), .rst(rst), .software_reset(software_reset),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_rdata(reg_rdata),
        .events(events), .auto_discharge_enable(auto_discharge_enable),
        .transmit_byte_count(transmit_byte_count), .hv_capable(hv_capable),
        .bus_power_raw(bus_power_raw), .fault_latch_status(fault_latch_status),
        .command_trigger(command_trigger), .wake_host_port(wake_host_port),
        .presence_detect_en(presence_detect_en),
        .bus_power_present_status(bus_power_present_status),
        .sink_path_en(sink_path_en), .source_en(source_en), .source_hv(source_hv));
    fscd_host h (.clock(clock), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_we(reg_we));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic test_done;
        $display("checks=%0d errors=%0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        h.rd(a, v);
        chk(v, exp);
    endtask
    task automatic pulse(input fscd_events_t e);
        @(posedge clock);
        events <= e;
        @(posedge clock);
        events <= '0;
    endtask
    task automatic swr;
        @(posedge clock);
        software_reset <= 1'b1;
        @(posedge clock);
        software_reset <= 1'b0;
    endtask
    task automatic cmd(input logic [7:0] op);
        h.wr(FSCD_CMD_ADDR, op);
        @(posedge clock);
        #1;
    endtask
    initial begin
        repeat (20000) @(posedge clock);
        n_errors++;
        test_done();
    end
    initial begin
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        rchk(FSCD_FAULT_ADDR, 8'h80);
        rchk(FSCD_CMD_ADDR, 8'h00);
        rchk(8'h20, 8'h00);
        h.wr(FSCD_FAULT_ADDR, 8'h7F);
        rchk(FSCD_FAULT_ADDR, 8'h80);
        h.wr(FSCD_FAULT_ADDR, 8'h80);
        swr();
        rchk(FSCD_FAULT_ADDR, 8'h00);
        for (int i = 0; i < 5; i++) begin
            pulse(fscd_events_t'(5'd1 << i));
            rchk(FSCD_FAULT_ADDR, EXP[i]);
            chk(fault_latch_status, EXP[i]);
            h.wr(FSCD_FAULT_ADDR, 8'hFF);
        end
        auto_discharge_enable <= 1'b0;
        transmit_byte_count <= FSCD_TX_MIN_BYTES;
        pulse(5'b10010);
        pulse(5'b00100);
        h.wr(FSCD_FAULT_ADDR, 8'h01);
        rchk(FSCD_FAULT_ADDR, 8'h02);
        h.wr(FSCD_FAULT_ADDR, 8'hFF);
        for (int i = 0; i < 12; i++) begin
            if (i == 4) swr();
            hv_capable <= HV[i];
            cmd(OPS[i]);
            chk(pw, PWS[i]);
            rchk(FSCD_FAULT_ADDR, {7'h00, ERR[i]});
            h.wr(FSCD_FAULT_ADDR, 8'h01);
        end
        swr();
        cmd(FSCD_OP_DIS_DET);
        chk(pw, 8'h00);
        @(posedge clock);
        bus_power_raw <= 1'b1;
        repeat (8) @(posedge clock);
        #1 chk({7'h00, bus_power_present_status}, 8'h00);
        cmd(FSCD_OP_EN_DET);
        repeat (8) @(posedge clock);
        #1 chk({7'h00, bus_power_present_status}, 8'h01);
        h.wr(FSCD_CMD_ADDR, FSCD_OP_WAKE);
        #1 chk(command_trigger, FSCD_OP_WAKE);
        @(posedge clock);
        #1 chk({7'h00, wake_host_port}, 8'h01);
        chk(command_trigger, 8'h00);
        chk(pw, 8'h01);
        rchk(FSCD_FAULT_ADDR, 8'h00);
        test_done();
    end
endmodule
`default_nettype wire

// ### test/fscd_host.sv
`timescale 1ns/1ps
`default_nettype none
// port manager side: one write strobe per register write
module fscd_host (
    input wire logic clock, // clock
    input wire logic [7:0] reg_rdata, // read data
    output logic [7:0] reg_addr, // address
    output logic [7:0] reg_wdata, // data
    output logic reg_we // strobe
);
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_we = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_we <= 1'b1;
        @(posedge clock);
        reg_we <= 1'b0;
        // released data is scrambled so stale values never pass
        reg_wdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        // read data is registered: it follows the address one edge later
        @(posedge clock);
        #1 d = reg_rdata;
    endtask
endmodule
`default_nettype wire

// ### test/fscd_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module fscd_monitor
    import fscd_pkg::*;
(
    input wire logic clock, // clock
    input wire logic rst, // reset
    input wire logic software_reset, // sw reset
    input wire logic [7:0] reg_addr, // address
    input wire logic [7:0] reg_wdata, // data
    input wire logic reg_we, // strobe
    input wire fscd_events_t events, // events
    input wire logic [7:0] fault_latch_status, // faults
    input wire logic [7:0] command_trigger, // command
    input wire logic wake_host_port, // wake
    input wire logic sink_path_en, // sink
    input wire logic source_en // source
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    wire logic wf = reg_we && reg_addr == FSCD_FAULT_ADDR;
    wire logic wc = reg_we && reg_addr == FSCD_CMD_ADDR;
    property p_take; wc && !software_reset |=> command_trigger == $past(reg_wdata); endproperty
    a_take: assert property (p_take) else $error("command not captured");
    property p_clr; command_trigger != 8'h00 && !wc |=> command_trigger == 8'h00; endproperty
    a_clr: assert property (p_clr) else $error("command not cleared");
    property p_rsv; (fault_latch_status & ~FSCD_FAULT_MASK) == 8'h00; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved fault bit set");
    property p_keep;
        !wf |=> (fault_latch_status & $past(fault_latch_status)) == $past(fault_latch_status);
    endproperty
    a_keep: assert property (p_keep) else $error("fault flag lost");
    property p_w1c;
        wf && events == '0 && command_trigger == 8'h00 |=> (fault_latch_status & $past(reg_wdata)) == 8'h00;
    endproperty
    a_w1c: assert property (p_w1c) else $error("flag not cleared");
    property p_ocp; events.ocp |=> fault_latch_status[FSCD_OCP_BIT]; endproperty
    a_ocp: assert property (p_ocp) else $error("overcurrent not latched");
    property p_sink_rej;
        command_trigger == FSCD_OP_SINK && source_en |=> fault_latch_status[0] && !sink_path_en;
    endproperty
    a_sink_rej: assert property (p_sink_rej) else $error("sink not refused");
    property p_wake; command_trigger == FSCD_OP_WAKE |=> wake_host_port ##1 !wake_host_port; endproperty
    a_wake: assert property (p_wake) else $error("wake pulse wrong");
    c_sink_rej: cover property (command_trigger == FSCD_OP_SINK && source_en);
    c_w1c: cover property (wf && fault_latch_status != 8'h00);
    c_wake: cover property (wake_host_port);
endmodule
bind fscd_top fscd_monitor u_mon (.clock(clock), .rst(rst), .software_reset(software_reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .events(events),
    .fault_latch_status(fault_latch_status), .command_trigger(command_trigger),
    .wake_host_port(wake_host_port), .sink_path_en(sink_path_en), .source_en(source_en));
`default_nettype wire
